// ### logic/uci_defines.svh
// constants for the serial channel interrupt logic: register offsets, field positions, codes, timing
// assumes a byte-addressed register map reached over a 32-bit avalon-mm slave, one word per register
`ifndef UCI_DEFINES_SVH
`define UCI_DEFINES_SVH
`define UCI_OFS_SOURCE_ENABLE 4'h4
`define UCI_OFS_PENDING_SOURCE 4'h8
`define UCI_OFS_CHANNEL_CTRL 4'hC
`define UCI_OFS_CHANNEL_STATUS 4'h0
`define UCI_EN_RX 0
`define UCI_EN_TX 1
`define UCI_EN_LINE 2
`define UCI_EN_MODEM 3
`define UCI_CTL_DIV_LSB 0
`define UCI_CTL_DIV_MSB 15
`define UCI_CTL_BUFMODE 16
`define UCI_CTL_TWO_STOP 17
`define UCI_CTL_CHAR_BITS_LSB 20
`define UCI_CTL_CHAR_BITS_MSB 23
`define UCI_CODE_NONE 4'h1
`define UCI_CODE_LINE 4'h6
`define UCI_CODE_RX 4'h4
`define UCI_CODE_TIMEOUT 4'hC
`define UCI_CODE_TX 4'h2
`define UCI_CODE_MODEM 4'h0
`define UCI_FIFO_ON_BITS 2'h3
`define UCI_TIMEOUT_CHARS 3'h4
`define UCI_BAUD_OVERSAMPLE 5'h10
`define UCI_DIV_RESET 16'h0001
`define UCI_CHAR_BITS_RESET 4'hA
`define UCI_FIFO_DEPTH 5'h10
`endif

// ### logic/uci_pkg.sv
// types for the serial channel interrupt logic
// assumes uci_defines.svh supplies the numeric constants
package uci_pkg;
	typedef enum logic [2:0] {
		uci_src_none,
		uci_src_line,
		uci_src_rx,
		uci_src_timeout,
		uci_src_tx,
		uci_src_modem
	} uci_source_type;
endpackage

// ### logic/uci_channel_irq.sv
// interrupt generation and identification for one serial channel, with an avalon-mm register slave
// assumes fifo, line and modem events arrive as one-cycle pulses on clock_i from channel logic
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "uci_defines.svh"

module uci_channel_irq
	import uci_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic rx_char_push_i,
	input wire logic rx_buffer_read_i,
	input wire logic [4:0] rx_level_i,
	input wire logic [4:0] rx_trigger_i,
	input wire logic tx_holding_write_i,
	input wire logic tx_char_pop_i,
	input wire logic line_state_read_i,
	input wire logic line_error_i,
	input wire logic modem_delta_i,
	input wire logic modem_state_read_i,
	output logic fifo_clear_o,
	output logic tx_holding_empty_o,
	output logic channel_irq_o
);

	if (FIFO_DEPTH != 16) begin : g_depth_check
		$error("uci_channel_irq: fifo depth must be 16");
	end

	////////////////////////////////////////////////////////////////
	// register slave

	logic [3:0] source_enable_reg;
	logic [15:0] divisor_reg;
	logic buffer_mode_enable_reg;
	logic two_stop_reg;
	logic [3:0] char_bits_reg;
	logic ack_reg;
	logic [7:0] pending_source_next;
	logic id_read;
	logic wr_ctrl;
	logic wr_en;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	// one wait cycle per access; answer on the edge after ack_reg rises
	assign wr_en = avs_write_i && ack_reg && hit(avs_address_i, `UCI_OFS_SOURCE_ENABLE) && avs_byteenable_i[0];
	assign wr_ctrl = avs_write_i && ack_reg && hit(avs_address_i, `UCI_OFS_CHANNEL_CTRL);
	assign id_read = avs_read_i && ack_reg && hit(avs_address_i, `UCI_OFS_PENDING_SOURCE);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_reg <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			source_enable_reg <= 4'h0;
		end else if (wr_en) begin
			source_enable_reg <= avs_writedata_i[3:0];
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			divisor_reg <= `UCI_DIV_RESET;
			buffer_mode_enable_reg <= 1'b0;
			two_stop_reg <= 1'b0;
			char_bits_reg <= `UCI_CHAR_BITS_RESET;
		end else if (wr_ctrl) begin
			if (avs_byteenable_i[0]) begin
				divisor_reg[7:0] <= avs_writedata_i[7:0];
			end
			if (avs_byteenable_i[1]) begin
				divisor_reg[15:8] <= avs_writedata_i[15:8];
			end
			if (avs_byteenable_i[2]) begin
				buffer_mode_enable_reg <= avs_writedata_i[`UCI_CTL_BUFMODE];
				two_stop_reg <= avs_writedata_i[`UCI_CTL_TWO_STOP];
				char_bits_reg <= avs_writedata_i[`UCI_CTL_CHAR_BITS_MSB:`UCI_CTL_CHAR_BITS_LSB];
			end
		end
	end

	logic mode_change;
	assign mode_change = wr_ctrl && avs_byteenable_i[2] &&
		(avs_writedata_i[`UCI_CTL_BUFMODE] != buffer_mode_enable_reg);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fifo_clear_o <= 1'b0;
		end else begin
			fifo_clear_o <= mode_change;
		end
	end

	////////////////////////////////////////////////////////////////
	// character time base

	logic [15:0] div_cnt_reg;
	logic [3:0] os_cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic bit_tick;
	logic char_tick;
	logic [3:0] char_len;

	// two stop bits lengthen each character time by one bit
	assign char_len = char_bits_reg + {3'h0, two_stop_reg};
	assign bit_tick = (div_cnt_reg == 16'h0001 || divisor_reg <= 16'h0001) && os_cnt_reg == 4'hF;
	assign char_tick = bit_tick && (bit_cnt_reg >= char_len - 4'h1);

	// reference clock divided by divisor, then by 16 per bit
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div_cnt_reg <= `UCI_DIV_RESET;
			os_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
		end else if (div_cnt_reg <= 16'h0001) begin
			div_cnt_reg <= divisor_reg;
			os_cnt_reg <= os_cnt_reg + 4'h1;
			if (bit_tick) begin
				bit_cnt_reg <= char_tick ? 4'h0 : bit_cnt_reg + 4'h1;
			end
		end else begin
			div_cnt_reg <= div_cnt_reg - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// receive time-out

	logic [2:0] to_cnt_reg;
	logic timeout_pend_reg;
	logic [7:0] to_sub_reg;
	logic os_tick;
	logic to_restart;
	logic to_char_tick;

	// counted from the restart in sixteenths of a bit, so the free bit phase cannot shorten the wait
	assign os_tick = div_cnt_reg <= 16'h0001;
	assign to_char_tick = os_tick && to_sub_reg == {char_len - 4'h1, 4'hF};
	assign to_restart = rx_buffer_read_i || mode_change ||
		(rx_char_push_i && !timeout_pend_reg) || rx_level_i == 5'h00;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			to_cnt_reg <= 3'h0;
			to_sub_reg <= 8'h00;
		end else if (to_restart) begin
			to_cnt_reg <= 3'h0;
			to_sub_reg <= 8'h00;
		end else if (os_tick && to_cnt_reg < `UCI_TIMEOUT_CHARS) begin
			to_sub_reg <= to_char_tick ? 8'h00 : to_sub_reg + 8'h01;
			if (to_char_tick) begin
				to_cnt_reg <= to_cnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timeout_pend_reg <= 1'b0;
		end else if (rx_buffer_read_i || !buffer_mode_enable_reg) begin
			timeout_pend_reg <= 1'b0;
		end else if (to_cnt_reg == `UCI_TIMEOUT_CHARS && rx_level_i != 5'h00 &&
			source_enable_reg[`UCI_EN_RX]) begin
			timeout_pend_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit empty

	logic [4:0] tx_level_reg;
	logic two_held_reg;
	logic first_after_mode_reg;
	logic [3:0] tx_delay_reg;
	logic tx_delaying_reg;
	logic tx_pend_reg;
	logic tx_going_empty;

	// processor writes are never refused; level saturates at depth
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_level_reg <= 5'h00;
		end else if (mode_change) begin
			tx_level_reg <= 5'h00;
		end else if (tx_holding_write_i && !tx_char_pop_i && tx_level_reg < `UCI_FIFO_DEPTH) begin
			tx_level_reg <= tx_level_reg + 5'h01;
		end else if (tx_char_pop_i && !tx_holding_write_i && tx_level_reg != 5'h00) begin
			tx_level_reg <= tx_level_reg - 5'h01;
		end
	end

	assign tx_going_empty = tx_char_pop_i && !tx_holding_write_i && tx_level_reg == 5'h01;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			two_held_reg <= 1'b0;
		end else if (tx_going_empty || mode_change) begin
			two_held_reg <= 1'b0;
		end else if (tx_level_reg >= 5'h02) begin
			two_held_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_after_mode_reg <= 1'b1;
		end else if (mode_change) begin
			first_after_mode_reg <= 1'b1;
		end else if ((tx_going_empty || tx_empty_rise) && source_enable_reg[`UCI_EN_TX]) begin
			first_after_mode_reg <= 1'b0;
		end
	end

	// delay counted in bits: character length less the final stop bit
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_delaying_reg <= 1'b0;
			tx_delay_reg <= 4'h0;
		end else if (tx_holding_write_i || mode_change) begin
			tx_delaying_reg <= 1'b0;
		end else if (tx_going_empty && buffer_mode_enable_reg && !two_held_reg && !first_after_mode_reg) begin
			tx_delaying_reg <= 1'b1;
			tx_delay_reg <= char_len - 4'h1;
		end else if (tx_delaying_reg && bit_tick) begin
			if (tx_delay_reg <= 4'h1) begin
				tx_delaying_reg <= 1'b0;
			end
			tx_delay_reg <= tx_delay_reg - 4'h1;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_holding_empty_o <= 1'b1;
		end else if (tx_holding_write_i) begin
			tx_holding_empty_o <= 1'b0;
		end else if (mode_change) begin
			tx_holding_empty_o <= 1'b1;
		end else if (tx_going_empty && !(buffer_mode_enable_reg && !two_held_reg && !first_after_mode_reg)) begin
			tx_holding_empty_o <= 1'b1;
		end else if (tx_delaying_reg && bit_tick && tx_delay_reg <= 4'h1) begin
			tx_holding_empty_o <= 1'b1;
		end
	end

	logic tx_empty_rise;
	logic tx_empty_d_reg;
	logic tx_en_d_reg;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_empty_d_reg <= 1'b1;
			tx_en_d_reg <= 1'b0;
		end else begin
			tx_empty_d_reg <= tx_holding_empty_o;
			tx_en_d_reg <= source_enable_reg[`UCI_EN_TX];
		end
	end

	// enabling while already empty also raises the source
	assign tx_empty_rise = tx_holding_empty_o &&
		(!tx_empty_d_reg || (source_enable_reg[`UCI_EN_TX] && !tx_en_d_reg));

	// set wins over clear in the same cycle
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_pend_reg <= 1'b0;
		end else if (tx_empty_rise && source_enable_reg[`UCI_EN_TX]) begin
			tx_pend_reg <= 1'b1;
		end else if (tx_holding_write_i || !source_enable_reg[`UCI_EN_TX] ||
			(id_read && avs_readdata_o[3:0] == `UCI_CODE_TX)) begin
			tx_pend_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// line and modem sources

	logic line_pend_reg;
	logic modem_pend_reg;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_pend_reg <= 1'b0;
		end else if (line_error_i) begin
			line_pend_reg <= 1'b1;
		end else if (line_state_read_i) begin
			line_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			modem_pend_reg <= 1'b0;
		end else if (modem_delta_i) begin
			modem_pend_reg <= 1'b1;
		end else if (modem_state_read_i) begin
			modem_pend_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// priority and identification

	logic rx_avail;
	uci_source_type source;

	// receive level reaches trigger in buffer mode, or any character otherwise
	assign rx_avail = buffer_mode_enable_reg ? (rx_level_i >= rx_trigger_i && rx_level_i != 5'h00) :
		(rx_level_i != 5'h00);

	always_comb begin
		source = uci_src_none;
		if (line_pend_reg && source_enable_reg[`UCI_EN_LINE]) begin
			source = uci_src_line;
		end else if (rx_avail && source_enable_reg[`UCI_EN_RX]) begin
			source = uci_src_rx;
		end else if (timeout_pend_reg && source_enable_reg[`UCI_EN_RX]) begin
			source = uci_src_timeout;
		end else if (tx_pend_reg && source_enable_reg[`UCI_EN_TX]) begin
			source = uci_src_tx;
		end else if (modem_pend_reg && source_enable_reg[`UCI_EN_MODEM]) begin
			source = uci_src_modem;
		end
	end

	always_comb begin
		pending_source_next = 8'h00;
		case (source)
			uci_src_line: pending_source_next[3:0] = `UCI_CODE_LINE;
			uci_src_rx: pending_source_next[3:0] = `UCI_CODE_RX;
			uci_src_timeout: pending_source_next[3:0] = buffer_mode_enable_reg ? `UCI_CODE_TIMEOUT :
				`UCI_CODE_RX;
			uci_src_tx: pending_source_next[3:0] = `UCI_CODE_TX;
			uci_src_modem: pending_source_next[3:0] = `UCI_CODE_MODEM;
			default: pending_source_next[3:0] = `UCI_CODE_NONE;
		endcase
		if (buffer_mode_enable_reg) begin
			pending_source_next[7:6] = `UCI_FIFO_ON_BITS;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			channel_irq_o <= 1'b0;
		end else begin
			channel_irq_o <= source != uci_src_none;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !ack_reg) begin
			case (avs_address_i)
				`UCI_OFS_SOURCE_ENABLE: avs_readdata_o <= {28'h0000000, source_enable_reg};
				`UCI_OFS_PENDING_SOURCE: avs_readdata_o <= {24'h000000, pending_source_next};
				`UCI_OFS_CHANNEL_CTRL: avs_readdata_o <= {8'h00, char_bits_reg, 2'h0, two_stop_reg,
					buffer_mode_enable_reg, divisor_reg};
				`UCI_OFS_CHANNEL_STATUS: avs_readdata_o <= {19'h00000, tx_level_reg, tx_holding_empty_o,
					line_pend_reg, modem_pend_reg, timeout_pend_reg, tx_pend_reg, to_cnt_reg};
				default: avs_readdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ### sim/uci_irq_props.sv
// checker for the channel interrupt ports
// assumes it is bound onto uci_channel_irq and sees only its ports
`timescale 1ns/1ps
module uci_irq_props (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic tx_holding_write_i,
	input wire logic tx_char_pop_i,
	input wire logic line_error_i,
	input wire logic modem_delta_i,
	input wire logic fifo_clear_o,
	input wire logic tx_holding_empty_o,
	input wire logic channel_irq_o
);
////////////////////////////////////////
logic [3:0] en_reg;
logic bm_reg;
wire logic wr_take = avs_write_i && !avs_waitrequest_o;
wire logic rd_take = avs_read_i && !avs_waitrequest_o;
always_ff @(posedge clock_i or negedge nrst_i) begin
	if (!nrst_i) en_reg <= 4'h0;
	else if (wr_take && avs_address_i == 4'h4 && avs_byteenable_i[0]) en_reg <= avs_writedata_i[3:0];
end
always_ff @(posedge clock_i or negedge nrst_i) begin
	if (!nrst_i) bm_reg <= 1'b0;
	else if (wr_take && avs_address_i == 4'hC && avs_byteenable_i[2]) bm_reg <= avs_writedata_i[16];
end
////////////////////////////////////////
default clocking cb @(posedge clock_i); endclocking
default disable iff (!nrst_i);
sequence s_ack;
	avs_waitrequest_o ##1 !avs_waitrequest_o;
endsequence
property p_wait; $rose(avs_read_i || avs_write_i) |-> s_ack; endproperty
a_wait: assert property (p_wait) else $error("bus answer not one cycle after request");
property p_stand; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
a_stand: assert property (p_stand) else $error("waitrequest low longer than one cycle");
property p_line; line_error_i && en_reg[2] |-> ##[1:2] channel_irq_o; endproperty
a_line: assert property (p_line) else $error("line error raised no interrupt");
property p_modem; modem_delta_i && en_reg[3] |-> ##[1:2] channel_irq_o; endproperty
a_modem: assert property (p_modem) else $error("modem change raised no interrupt");
property p_quiet; en_reg == 4'h0 && $past(en_reg) == 4'h0 && $past(en_reg, 2) == 4'h0 |-> !channel_irq_o; endproperty
a_quiet: assert property (p_quiet) else $error("interrupt with all sources disabled");
property p_txw; tx_holding_write_i && !tx_char_pop_i |-> ##[1:2] !tx_holding_empty_o; endproperty
a_txw: assert property (p_txw) else $error("transmit write left empty set");
property p_clear; wr_take && avs_address_i == 4'hC && avs_byteenable_i[2] && avs_writedata_i[16] != bm_reg
	|=> fifo_clear_o ##1 !fifo_clear_o; endproperty
a_clear: assert property (p_clear) else $error("mode change gave no clear pulse");
property p_en_rd; rd_take && avs_address_i == 4'h4 |-> avs_readdata_o[31:4] == 28'h0; endproperty
a_en_rd: assert property (p_en_rd) else $error("enable upper bits not zero");
property p_id_rd; rd_take && avs_address_i == 4'h8 |-> avs_readdata_o[7:4] == {bm_reg, bm_reg, 2'h0}; endproperty
a_id_rd: assert property (p_id_rd) else $error("id upper bits wrong");
endmodule
bind uci_channel_irq uci_irq_props u_props (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.tx_holding_write_i(tx_holding_write_i), .tx_char_pop_i(tx_char_pop_i), .line_error_i(line_error_i),
	.modem_delta_i(modem_delta_i), .fifo_clear_o(fifo_clear_o), .tx_holding_empty_o(tx_holding_empty_o),
	.channel_irq_o(channel_irq_o));

// ### sim/uci_host_model.sv
// host processor model: avalon-mm master for the channel registers
// assumes the slave answers with waitrequest low; the bench watchdog ends hangs
`timescale 1ns/1ps
module uci_host_model (
	input wire logic clock_i,
	output logic [3:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [31:0] avs_writedata_o,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i
);
initial begin
	avs_address_o = 4'h0;
	avs_read_o = 1'b0;
	avs_write_o = 1'b0;
	avs_writedata_o = 32'h0;
end
task automatic bus_cycle(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
	@(posedge clock_i);
	avs_address_o <= a;
	avs_writedata_o <= d;
	avs_read_o <= !w;
	avs_write_o <= w;
	@(posedge clock_i);
	while (avs_waitrequest_i !== 1'b0) @(posedge clock_i);
	q = avs_readdata_i;
	avs_read_o <= 1'b0;
	avs_write_o <= 1'b0;
	// released lines show no stale value
	avs_address_o <= ~a;
	avs_writedata_o <= ~d;
endtask
endmodule

// ### sim/uci_channel_irq_tb_top.sv
// self-checking bench for the channel interrupt logic
// assumes the host model drives the register bus; events are driven here
`timescale 1ns/1ps
module uci_channel_irq_tb_top;
typedef struct packed {logic [3:0] en; logic [7:0] ev; logic [4:0] lvl; logic [7:0] id;} uci_row_type;
typedef struct packed {logic [15:0] div; logic ts; logic rs; logic [3:0] en;} uci_tout_type;
logic clock_i, nrst_i, rd, wr, wreq, fclr, temp, irq;
logic [3:0] adr;
logic [31:0] wd, rdat, q;
logic [7:0] ev;
logic [4:0] lvl;
int mismatches, checked, t, clears;
uci_row_type rows [6] = '{'{4'h4, 8'h10, 5'h00, 8'h06}, '{4'hC, 8'h30, 5'h00, 8'h06},
	'{4'h8, 8'h20, 5'h00, 8'h00}, '{4'h1, 8'h00, 5'h04, 8'h04}, '{4'h5, 8'h10, 5'h04, 8'h06},
	'{4'h0, 8'h30, 5'h04, 8'h01}};
uci_tout_type touts [5] = '{'{16'h1, 1'b0, 1'b0, 4'h1}, '{16'h2, 1'b0, 1'b0, 4'h1},
	'{16'h1, 1'b1, 1'b0, 4'h1}, '{16'h1, 1'b0, 1'b1, 4'h1}, '{16'h1, 1'b0, 1'b0, 4'h0}};
////////////////////////////////////////
uci_host_model u_host (.clock_i(clock_i), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
	.avs_writedata_o(wd), .avs_readdata_i(rdat), .avs_waitrequest_i(wreq));
uci_channel_irq DUT (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
	.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
	.avs_waitrequest_o(wreq), .rx_char_push_i(ev[0]), .rx_buffer_read_i(ev[1]), .rx_level_i(lvl),
	.rx_trigger_i(5'h04), .tx_holding_write_i(ev[2]), .tx_char_pop_i(ev[3]), .line_state_read_i(ev[6]),
	.line_error_i(ev[4]), .modem_delta_i(ev[5]), .modem_state_read_i(ev[7]), .fifo_clear_o(fclr),
	.tx_holding_empty_o(temp), .channel_irq_o(irq));
initial begin
	clock_i = 1'b0;
	forever #4 clock_i = ~clock_i;
end
always @(posedge clock_i) begin
	if (fclr === 1'b1) clears <= clears + 1;
end
////////////////////////////////////////
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	checked++;
	if (seen !== exp) begin
		mismatches++;
		$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic pulse(input logic [7:0] m);
	@(posedge clock_i);
	ev <= m;
	@(posedge clock_i);
	ev <= 8'h00;
endtask
task automatic gap(input int n);
	repeat (n) @(posedge clock_i);
endtask
task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
	u_host.bus_cycle(1'b1, a, d, q);
endtask
task automatic rd_reg(input logic [3:0] a);
	u_host.bus_cycle(1'b0, a, 32'h0, q);
endtask
function automatic logic [31:0] cw(input logic [15:0] div, input logic ts, input logic bm);
	return {8'h00, 4'hA, 2'h0, ts, bm, div};
endfunction
task automatic print_verdict;
	$display("counts: %0d checked, %0d mismatches", checked, mismatches);
	if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
////////////////////////////////////////
initial begin
	gap(60000);
	mismatches++;
	print_verdict();
end
initial begin
	nrst_i = 1'b0;
	ev = 8'h00;
	lvl = 5'h00;
	gap(10);
	nrst_i <= 1'b1;
	gap(1);
	chk({31'h0, irq}, 32'h0);
	rd_reg(4'h4);
	chk(q, 32'h0);
	rd_reg(4'h8);
	chk(q, 32'h1);
	wr_reg(4'h4, 32'hFF);
	rd_reg(4'h4);
	chk(q, 32'h0F);
	rd_reg(4'h8);
	chk(q, 32'h02);
	gap(3);
	chk({31'h0, irq}, 32'h0);
	$display("test reset and enables done");
	foreach (rows[i]) begin
		wr_reg(4'h4, {28'h0, rows[i].en});
		lvl <= rows[i].lvl;
		pulse(rows[i].ev);
		gap(3);
		rd_reg(4'h8);
		chk(q, {24'h0, rows[i].id});
		chk({31'h0, irq}, {31'h0, rows[i].id != 8'h01});
		lvl <= 5'h00;
		pulse(8'hC0);
		gap(2);
		rd_reg(4'h8);
		chk(q, 32'h1);
	end
	$display("test priority table done");
	lvl <= 5'h01;
	foreach (touts[i]) begin
		wr_reg(4'hC, cw(touts[i].div, touts[i].ts, 1'b1));
		wr_reg(4'h4, {28'h0, touts[i].en});
		t = 64 * int'(touts[i].div) * (10 + int'(touts[i].ts));
		pulse(8'h01);
		if (touts[i].rs) begin
			gap(t / 2);
			pulse(8'h02);
		end
		gap(t - 24);
		chk({31'h0, irq}, 32'h0);
		gap(64);
		chk({31'h0, irq}, {31'h0, touts[i].en != 4'h0});
		rd_reg(4'h8);
		chk(q, (touts[i].en != 4'h0) ? 32'hCC : 32'hC1);
		pulse(8'h02);
		gap(3);
		chk({31'h0, irq}, 32'h0);
	end
	$display("test receive time-out done");
	lvl <= 5'h00;
	wr_reg(4'h4, 32'h2);
	gap(3);
	rd_reg(4'h8);
	chk(q, 32'hC2);
	gap(3);
	chk({31'h0, irq}, 32'h0);
	pulse(8'h04);
	pulse(8'h08);
	gap(100);
	chk({31'h0, temp}, 32'h0);
	gap(60);
	chk({31'h0, temp}, 32'h1);
	chk({31'h0, irq}, 32'h1);
	repeat (16) pulse(8'h04);
	gap(2);
	chk({31'h0, irq}, 32'h0);
	rd_reg(4'h0);
	chk({27'h0, q[12:8]}, 32'h10);
	repeat (16) pulse(8'h08);
	gap(4);
	chk({31'h0, temp}, 32'h1);
	rd_reg(4'h8);
	wr_reg(4'hC, cw(16'h1, 1'b0, 1'b0));
	wr_reg(4'hC, cw(16'h1, 1'b0, 1'b1));
	pulse(8'h04);
	pulse(8'h08);
	gap(6);
	chk({31'h0, temp}, 32'h1);
	chk(clears, 32'h3);
	$display("test transmit empty done");
	print_verdict();
end
endmodule
